/* File: rtl/prx_readout.sv */
// Proximity readout core with serial registers and event pin
`include "prx_defs.svh"
`default_nettype none
module prx_readout import prx_pkg::*; #(
  // Arbitrary identification value
  parameter logic [7:0] ID_CODE = 8'h5A
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic sensor_osc_i,
  input wire logic [15:0] tank_resistance_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic event_pin_n_o
);
  // Reset release
  logic [1:0] rst_sync_reg;
  wire rst_n = rst_sync_reg[1];

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // Serial port in the link clock domain
  prx_map_type mirror_reg;
  prx_wr_type wr_link;
  logic wr_tog_link;
  logic rd_tog_link;

  prx_spi_link #(
    .ID_CODE(ID_CODE)
  ) u_link (
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .sdi_i(sdi_i),
    .rst_n_i(rst_n),
    .map_i(mirror_reg),
    .wr_o(wr_link),
    .wr_tog_o(wr_tog_link),
    .rd_tog_o(rd_tog_link),
    .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o)
  );

  // Input synchronisers
  logic [1:0] osc_s_reg;
  logic osc_d_reg;
  logic [1:0] cs_s_reg;
  logic [1:0] wr_s_reg;
  logic wr_d_reg;
  logic [1:0] rd_s_reg;
  logic rd_d_reg;
  logic [15:0] tank_s1_reg;
  logic [15:0] tank_s2_reg;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      osc_s_reg <= 2'b00;
      osc_d_reg <= 1'b0;
      cs_s_reg <= 2'b11;
      wr_s_reg <= 2'b00;
      wr_d_reg <= 1'b0;
      rd_s_reg <= 2'b00;
      rd_d_reg <= 1'b0;
      tank_s1_reg <= 16'h0000;
      tank_s2_reg <= 16'h0000;
    end else begin
      osc_s_reg <= {osc_s_reg[0], sensor_osc_i};
      osc_d_reg <= osc_s_reg[1];
      cs_s_reg <= {cs_s_reg[0], cs_n_i};
      wr_s_reg <= {wr_s_reg[0], wr_tog_link};
      wr_d_reg <= wr_s_reg[1];
      rd_s_reg <= {rd_s_reg[0], rd_tog_link};
      rd_d_reg <= rd_s_reg[1];
      tank_s1_reg <= tank_resistance_i;
      tank_s2_reg <= tank_s1_reg;
    end
  end

  wire tick_w = osc_s_reg[1] & ~osc_d_reg;
  wire frame_w = ~cs_s_reg[1];
  wire wr_ev_w = wr_s_reg[1] ^ wr_d_reg;
  wire rd_ev_w = rd_s_reg[1] ^ rd_d_reg;

  // Register write decode
  logic [7:0] ceil_reg;
  logic [7:0] floor_reg;
  logic [7:0] thr_hi_reg;
  logic [7:0] thr_lo_reg;
  logic [2:0] evmode_reg;
  logic pwr_reg;

  wire wr_ceil_w = wr_ev_w & (wr_link.addr == `PRX_ADDR_CEIL) & ~pwr_reg;
  wire wr_floor_w = wr_ev_w & (wr_link.addr == `PRX_ADDR_FLOOR) & ~pwr_reg;
  wire wr_thr_hi_w = wr_ev_w & (wr_link.addr == `PRX_ADDR_THR_HI);
  wire wr_thr_lo_w = wr_ev_w & (wr_link.addr == `PRX_ADDR_THR_LO);
  wire wr_evmode_w = wr_ev_w & (wr_link.addr == `PRX_ADDR_EVMODE);
  wire wr_pwr_w = wr_ev_w & (wr_link.addr == `PRX_ADDR_PWR);

  // Range limits and thresholds
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ceil_reg <= `PRX_RST_CEIL;
      floor_reg <= `PRX_RST_FLOOR;
      thr_hi_reg <= `PRX_RST_THR_HI;
      thr_lo_reg <= `PRX_RST_THR_LO;
    end else begin
      if (wr_ceil_w) begin
        ceil_reg <= wr_link.data;
      end
      if (wr_floor_w) begin
        floor_reg <= wr_link.data;
      end
      if (wr_thr_hi_w) begin
        thr_hi_reg <= wr_link.data;
      end
      if (wr_thr_lo_w) begin
        thr_lo_reg <= wr_link.data;
      end
    end
  end

  // Event mode and power mode, standby after reset
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      evmode_reg <= `PRX_RST_EVMODE;
      pwr_reg <= `PRX_RST_PWR;
    end else begin
      if (wr_evmode_w) begin
        evmode_reg <= wr_link.data[`PRX_EVMODE_W-1:0];
      end
      if (wr_pwr_w) begin
        pwr_reg <= wr_link.data[`PRX_PWR_BIT];
      end
    end
  end

  // Output rate timer counted in sensor periods
  logic [7:0] period_cnt_reg;
  wire period_end_w = tick_w & (period_cnt_reg == `PRX_CONV_PERIODS - 8'h01);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt_reg <= 8'h00;
    end else if (!pwr_reg) begin
      period_cnt_reg <= 8'h00;
    end else if (period_end_w) begin
      period_cnt_reg <= 8'h00;
    end else if (tick_w) begin
      period_cnt_reg <= period_cnt_reg + 8'h01;
    end
  end

  // Conversion arithmetic
  prx_state_type state_reg;
  wire conv_start_w = period_end_w & pwr_reg & (state_reg == PRX_IDLE);
  wire [15:0] rp_w = tank_s2_reg;
  wire [15:0] rmin_w = {floor_reg, 8'h00};
  wire [15:0] rmax_w = {ceil_reg, 8'h00};
  wire under_w = rp_w < rmin_w;
  wire over_w = rp_w >= rmax_w;
  wire [31:0] num_prod_w = rmin_w * (rmax_w - rp_w);
  wire [31:0] den_w = rp_w * (rmax_w - rmin_w);
  // Code = 2^7 * floor * (ceiling - r) / (r * (ceiling - floor))
  wire [39:0] num_w = {1'b0, num_prod_w, 7'h00};
  wire sat_w = num_w >= {den_w, 8'h00};

  logic [39:0] rem_reg;
  logic [39:0] dsh_reg;
  logic [7:0] quot_reg;
  logic [2:0] div_cnt_reg;
  logic [7:0] result_reg;
  logic conv_done_reg;

  wire ge_w = rem_reg >= dsh_reg;
  wire [39:0] rem_next = ge_w ? rem_reg - dsh_reg : rem_reg;
  wire [7:0] quot_next = {quot_reg[6:0], ge_w};
  wire div_last_w = div_cnt_reg == `PRX_DIV_LAST;

  // Sequential divider, one quotient bit per clock
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PRX_IDLE;
      rem_reg <= 40'h00_0000_0000;
      dsh_reg <= 40'h00_0000_0000;
      quot_reg <= 8'h00;
      div_cnt_reg <= `PRX_DIV_FIRST;
      result_reg <= `PRX_CODE_ZERO;
      conv_done_reg <= 1'b0;
    end else begin
      conv_done_reg <= 1'b0;
      unique case (state_reg)
        PRX_IDLE: begin
          if (conv_start_w) begin
            if (under_w | sat_w) begin
              result_reg <= `PRX_CODE_FULL;
              conv_done_reg <= 1'b1;
            end else if (over_w) begin
              result_reg <= `PRX_CODE_ZERO;
              conv_done_reg <= 1'b1;
            end else begin
              rem_reg <= num_w;
              dsh_reg <= {1'b0, den_w, 7'h00};
              quot_reg <= 8'h00;
              div_cnt_reg <= `PRX_DIV_FIRST;
              state_reg <= PRX_DIV;
            end
          end
        end
        PRX_DIV: begin
          rem_reg <= rem_next;
          dsh_reg <= {1'b0, dsh_reg[39:1]};
          quot_reg <= quot_next;
          div_cnt_reg <= div_cnt_reg - 3'h1;
          if (div_last_w) begin
            result_reg <= quot_next;
            conv_done_reg <= 1'b1;
            state_reg <= PRX_IDLE;
          end
        end
      endcase
    end
  end

  // Event pin behaviour
  wire mode_comp_w = evmode_reg == `PRX_EV_COMP;
  wire mode_wake_w = evmode_reg == `PRX_EV_WAKE;
  wire mode_done_w = evmode_reg == `PRX_EV_DONE;
  wire above_hi_w = conv_done_reg & (result_reg > thr_hi_reg);
  wire below_lo_w = conv_done_reg & (result_reg < thr_lo_reg);

  logic comp_reg;
  logic wake_reg;
  logic done_reg;
  logic pulse_reg;
  logic event_n_reg;

  // Hysteresis comparator on each new code
  wire comp_next = !mode_comp_w ? 1'b0 :
                   above_hi_w ? 1'b1 :
                   below_lo_w ? 1'b0 : comp_reg;
  // Wake latch held until the mode is left
  wire wake_next = !mode_wake_w ? 1'b0 :
                   above_hi_w ? 1'b1 : wake_reg;
  // Data flag, a new conversion outside a frame wins over a read
  wire done_set_w = conv_done_reg & ~frame_w;
  wire done_next = done_set_w ? 1'b1 :
                   rd_ev_w ? 1'b0 : done_reg;
  // Pulse from conversion to the next sensor period edge
  wire pulse_next = conv_done_reg ? 1'b1 :
                    tick_w ? 1'b0 : pulse_reg;
  wire event_w = (mode_comp_w & comp_reg) |
                 (mode_wake_w & wake_reg) |
                 (mode_done_w & (done_reg | pulse_reg));

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      comp_reg <= 1'b0;
      wake_reg <= 1'b0;
      done_reg <= 1'b0;
      pulse_reg <= 1'b0;
      event_n_reg <= 1'b1;
    end else begin
      comp_reg <= comp_next;
      wake_reg <= wake_next;
      done_reg <= done_next;
      pulse_reg <= pulse_next;
      event_n_reg <= ~event_w;
    end
  end

  // Readable map, frozen while a frame is open
  wire [7:0] status_w = ({7'h00, comp_reg} << `PRX_ST_COMP) |
                        ({7'h00, wake_reg} << `PRX_ST_WAKE) |
                        ({7'h00, ~done_reg} << `PRX_ST_DONE_N);
  prx_map_type map_w;
  assign map_w.ceil = ceil_reg;
  assign map_w.floor = floor_reg;
  assign map_w.thr_hi = thr_hi_reg;
  assign map_w.thr_lo = thr_lo_reg;
  assign map_w.evmode = {5'h00, evmode_reg};
  assign map_w.pwr = {7'h00, pwr_reg};
  assign map_w.status = status_w;
  assign map_w.result = result_reg;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      mirror_reg <= '0;
    end else if (!frame_w) begin
      mirror_reg <= map_w;
    end
  end

  assign event_pin_n_o = event_n_reg;
endmodule : prx_readout
`default_nettype wire

/* File: rtl/prx_defs.svh */
// Constants for the proximity readout block
`ifndef PRX_DEFS_SVH
`define PRX_DEFS_SVH
`define PRX_ADDR_ID 7'h00
`define PRX_ADDR_CEIL 7'h01
`define PRX_ADDR_FLOOR 7'h02
`define PRX_ADDR_THR_HI 7'h07
`define PRX_ADDR_THR_LO 7'h09
`define PRX_ADDR_EVMODE 7'h0A
`define PRX_ADDR_PWR 7'h0B
`define PRX_ADDR_STATUS 7'h20
`define PRX_ADDR_RESULT 7'h22
`define PRX_RST_CEIL 8'h0E
`define PRX_RST_FLOOR 8'h14
`define PRX_RST_THR_HI 8'hFF
`define PRX_RST_THR_LO 8'h00
`define PRX_RST_EVMODE 3'h0
`define PRX_RST_PWR 1'b0
`define PRX_RST_BYTE 8'h00
`define PRX_EV_OFF 3'h0
`define PRX_EV_WAKE 3'h1
`define PRX_EV_COMP 3'h2
`define PRX_EV_DONE 3'h4
`define PRX_PWR_BIT 0
`define PRX_EVMODE_W 3
`define PRX_ST_COMP 4
`define PRX_ST_WAKE 5
`define PRX_ST_DONE_N 6
`define PRX_CONV_PERIODS 8'hC0
`define PRX_CODE_FULL 8'hFF
`define PRX_CODE_ZERO 8'h00
`define PRX_BYTE_FIRST 3'h0
`define PRX_BYTE_LAST 3'h7
`define PRX_DIV_LAST 3'h0
`define PRX_DIV_FIRST 3'h7
`endif

/* File: rtl/prx_pkg.sv */
// Types shared by the proximity readout block
`default_nettype none
package prx_pkg;
  typedef struct packed {
    logic [7:0] ceil;
    logic [7:0] floor;
    logic [7:0] thr_hi;
    logic [7:0] thr_lo;
    logic [7:0] evmode;
    logic [7:0] pwr;
    logic [7:0] status;
    logic [7:0] result;
  } prx_map_type;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } prx_wr_type;
  typedef enum logic [1:0] {
    PRX_IDLE,
    PRX_DIV
  } prx_state_type;
endpackage : prx_pkg
`default_nettype wire

/* File: rtl/prx_spi_link.sv */
// Serial port logic on the serial clock
`include "prx_defs.svh"
`default_nettype none
module prx_spi_link import prx_pkg::*; #(
  parameter logic [7:0] ID_CODE = 8'h5A
) (
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic rst_n_i,
  input wire prx_map_type map_i,
  output prx_wr_type wr_o,
  output logic wr_tog_o,
  output logic rd_tog_o,
  output logic sdo_o,
  output logic sdo_oe_o
);
  logic [2:0] bit_cnt_reg;
  logic cmd_seen_reg;
  logic read_reg;
  logic [6:0] addr_reg;
  logic [6:0] shin_reg;
  logic [7:0] shout_reg;
  prx_wr_type wr_reg;
  logic wr_tog_reg;
  logic rd_tog_reg;

  wire byte_end_w = bit_cnt_reg == `PRX_BYTE_LAST;
  wire [7:0] byte_w = {shin_reg, sdi_i};
  wire [6:0] addr_inc_w = addr_reg + 7'h01;
  wire rd_cmd_w = byte_end_w & ~cmd_seen_reg & byte_w[7] & (byte_w[6:0] == `PRX_ADDR_RESULT);
  wire rd_ext_w = byte_end_w & cmd_seen_reg & read_reg & (addr_inc_w == `PRX_ADDR_RESULT);
  wire wr_fire_w = byte_end_w & cmd_seen_reg & ~read_reg;
  wire load_w = cmd_seen_reg & read_reg & (bit_cnt_reg == `PRX_BYTE_FIRST);
  wire [7:0] rdata_w =
    (addr_reg == `PRX_ADDR_ID) ? ID_CODE :
    (addr_reg == `PRX_ADDR_CEIL) ? map_i.ceil :
    (addr_reg == `PRX_ADDR_FLOOR) ? map_i.floor :
    (addr_reg == `PRX_ADDR_THR_HI) ? map_i.thr_hi :
    (addr_reg == `PRX_ADDR_THR_LO) ? map_i.thr_lo :
    (addr_reg == `PRX_ADDR_EVMODE) ? map_i.evmode :
    (addr_reg == `PRX_ADDR_PWR) ? map_i.pwr :
    (addr_reg == `PRX_ADDR_STATUS) ? map_i.status :
    (addr_reg == `PRX_ADDR_RESULT) ? map_i.result : `PRX_RST_BYTE;

  // Command byte then data bytes, auto increment
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_reg <= `PRX_BYTE_FIRST;
      cmd_seen_reg <= 1'b0;
      read_reg <= 1'b0;
      addr_reg <= 7'h00;
      shin_reg <= 7'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shin_reg <= byte_w[6:0];
      if (byte_end_w) begin
        cmd_seen_reg <= 1'b1;
        read_reg <= cmd_seen_reg ? read_reg : byte_w[7];
        addr_reg <= cmd_seen_reg ? addr_inc_w : byte_w[6:0];
      end
    end
  end

  // Write and result-read events toward the core
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_reg <= '0;
      wr_tog_reg <= 1'b0;
      rd_tog_reg <= 1'b0;
    end else begin
      if (wr_fire_w) begin
        wr_reg <= '{addr: addr_reg, data: byte_w};
        wr_tog_reg <= ~wr_tog_reg;
      end
      if (rd_cmd_w | rd_ext_w) begin
        rd_tog_reg <= ~rd_tog_reg;
      end
    end
  end

  // Read data leaves on the falling edge
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      shout_reg <= `PRX_RST_BYTE;
    end else if (load_w) begin
      shout_reg <= rdata_w;
    end else begin
      shout_reg <= {shout_reg[6:0], 1'b0};
    end
  end

  assign wr_o = wr_reg;
  assign wr_tog_o = wr_tog_reg;
  assign rd_tog_o = rd_tog_reg;
  assign sdo_o = shout_reg[7];
  assign sdo_oe_o = ~cs_n_i & cmd_seen_reg & read_reg;
endmodule : prx_spi_link
`default_nettype wire

/* File: dv/prx_readout_asserts.sv */
// Port-level assertions for the proximity readout block
`default_nettype none
module prx_readout_asserts #(
  parameter logic [7:0] ID_CODE = 8'h5A
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic sensor_osc_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic event_pin_n_o
);
  logic [5:0] bits_reg;
  logic [7:0] cmd_reg;
  logic [2:0] osc_reg;
  logic [7:0] ticks_reg;
  wire logic mapped = cmd_reg[6:0] inside {7'h00, 7'h01, 7'h02, 7'h07, 7'h09, 7'h0A, 7'h0B, 7'h20, 7'h22};
  wire logic rd_byte = cmd_reg[7] && bits_reg >= 6'h08 && bits_reg < 6'h10;
  // Frame bit count and command capture
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bits_reg <= 6'h00;
      cmd_reg <= 8'h00;
    end else if (bits_reg < 6'h3F) begin
      bits_reg <= bits_reg + 6'h01;
      if (bits_reg < 6'h08) cmd_reg <= {cmd_reg[6:0], sdi_i};
    end
  end
  // Sensor ticks since reset
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_reg <= 3'h0;
      ticks_reg <= 8'h00;
    end else begin
      osc_reg <= {osc_reg[1:0], sensor_osc_i};
      if (osc_reg[1] && !osc_reg[2] && ticks_reg != 8'hFF) ticks_reg <= ticks_reg + 8'h01;
    end
  end
  sequence read_cmd_s;
    cmd_reg[7] && bits_reg == 6'h08;
  endsequence
  rst_release_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> event_pin_n_o ##1 event_pin_n_o) else $error("pin low at reset");
  oe_idle_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    cs_n_i |-> !sdo_oe_o) else $error("sdo driven outside frame");
  oe_held_a: assert property (@(negedge sclk_i) disable iff (!rst_n_i || cs_n_i)
    read_cmd_s |-> sdo_oe_o [*8]) else $error("sdo not driven on read");
  oe_early_a: assert property (@(negedge sclk_i) disable iff (!rst_n_i || cs_n_i)
    bits_reg < 6'h08 |-> !sdo_oe_o) else $error("sdo driven in command");
  oe_write_a: assert property (@(negedge sclk_i) disable iff (!rst_n_i || cs_n_i)
    bits_reg >= 6'h08 && !cmd_reg[7] |-> !sdo_oe_o) else $error("sdo driven on write");
  id_bits_a: assert property (@(posedge sclk_i) disable iff (!rst_n_i || cs_n_i)
    rd_byte && cmd_reg[6:0] == 7'h00 |-> sdo_o == ID_CODE[3'h7 - bits_reg[2:0]]) else $error("id bit wrong");
  unm_zero_a: assert property (@(posedge sclk_i) disable iff (!rst_n_i || cs_n_i)
    rd_byte && !mapped |-> !sdo_o) else $error("unmapped read not zero");
  fall_late_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $fell(event_pin_n_o) |-> ticks_reg >= 8'hC0) else $error("event before first conversion");
endmodule : prx_readout_asserts
bind prx_readout prx_readout_asserts #(.ID_CODE(ID_CODE)) i_prx_readout_asserts (
  .clock_i(clock_i),
  .rst_n_i(rst_n_i),
  .sensor_osc_i(sensor_osc_i),
  .sclk_i(sclk_i),
  .cs_n_i(cs_n_i),
  .sdi_i(sdi_i),
  .sdo_o(sdo_o),
  .sdo_oe_o(sdo_oe_o),
  .event_pin_n_o(event_pin_n_o)
);
`default_nettype wire

/* File: dv/prx_host_model.sv */
// Behavioural host on the serial port
`default_nettype none
module prx_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // Fewer than 16 clocks aborts the frame
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int nclk, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    cs_n_o = 1'b0;
    #20;
    for (int i = 0; i < nclk; i++) begin
      sdi_o = sh[15 - i];
      #15;
      sclk_o = 1'b1;
      rd = {rd[6:0], sdo_i};
      #15;
      sclk_o = 1'b0;
      if (i == 7) #300;
    end
    #20;
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    #200;
  endtask : xfer
endmodule : prx_host_model
`default_nettype wire

/* File: dv/proximity_readout_event_pin_tb.sv */
// Self-checking bench for the proximity readout block
`default_nettype none
`include "prx_defs.svh"
module proximity_readout_event_pin_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID_VAL = 8'h3C; // Arbitrary identification value
  localparam logic [7:0] FL = 8'h10;
  localparam logic [7:0] CE = 8'h40;
  localparam int SETTLE = 3112;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sensor_osc_i = 1'b0;
  logic [15:0] tank_resistance_i = 16'h0FFF;
  logic [1:0] div_reg = 2'h0;
  logic sclk_w, cs_n_w, sdi_w, sdo_w, sdo_o, sdo_oe_o, event_pin_n_o;
  logic sdo_last = 1'b0;
  int num_errors = 0;
  int n_checks = 0;
  int seed = 32'h40c6;
  int r;
  logic [7:0] d;
  logic [6:0] ra[9] = '{7'h00, 7'h01, 7'h02, 7'h07, 7'h09, 7'h0A, 7'h0B, 7'h22, 7'h30};
  logic [7:0] rv[9] = '{ID_VAL, 8'h0E, 8'h14, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  always #25 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    div_reg <= div_reg + 2'h1;
    if (div_reg == 2'h3) sensor_osc_i <= ~sensor_osc_i;
  end
  always @(sdo_o or sdo_oe_o) if (sdo_oe_o) sdo_last = sdo_o;
  assign sdo_w = sdo_oe_o ? sdo_o : ~sdo_last;
  prx_readout #(.ID_CODE(ID_VAL)) i_prx_readout (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .sensor_osc_i(sensor_osc_i),
    .tank_resistance_i(tank_resistance_i),
    .sclk_i(sclk_w),
    .cs_n_i(cs_n_w),
    .sdi_i(sdi_w),
    .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o),
    .event_pin_n_o(event_pin_n_o)
  );
  prx_host_model i_prx_host_model (
    .sclk_o(sclk_w),
    .cs_n_o(cs_n_w),
    .sdi_o(sdi_w),
    .sdo_i(sdo_w)
  );
  function automatic logic [7:0] model_code(input int rr);
    longint f, c, q;
    f = 256 * FL;
    c = 256 * CE;
    if (rr < f) return 8'hFF;
    if (rr >= c) return 8'h00;
    q = 128 * f * (c - rr) / (rr * (c - f));
    return q > 255 ? 8'hFF : q[7:0];
  endfunction : model_code
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic pin(input logic e);
    check({7'h00, event_pin_n_o}, {7'h00, e});
  endtask : pin
  task automatic wr(input logic [6:0] a, input logic [7:0] v, input int n = 16);
    logic [7:0] x;
    i_prx_host_model.xfer({1'b0, a}, v, n, x);
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    i_prx_host_model.xfer({1'b1, a}, 8'h00, 16, v);
  endtask : rd
  task automatic settle(input int rr, input int n);
    @(posedge clock_i);
    tank_resistance_i <= rr[15:0];
    repeat (n) @(posedge clock_i);
  endtask : settle
  task automatic run_mode(input logic [2:0] m);
    int seq[4] = '{32'h1400, 32'h0FFF, 32'h1400, 32'h3000};
    logic st;
    st = 1'b0;
    wr(`PRX_ADDR_EVMODE, {5'h00, m});
    foreach (seq[i]) begin
      settle(seq[i], SETTLE);
      if (model_code(seq[i]) > 8'h80) st = 1'b1;
      else if (model_code(seq[i]) < 8'h40 && m == `PRX_EV_COMP) st = 1'b0;
      pin(!st);
    end
    $display("test mode %0d done", m);
  endtask : run_mode
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (60000) @(posedge clock_i);
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    foreach (ra[i]) begin
      rd(ra[i], d);
      check(d, rv[i]);
    end
    $display("test reset values done");
    wr(`PRX_ADDR_CEIL, CE);
    wr(`PRX_ADDR_FLOOR, FL);
    wr(`PRX_ADDR_THR_HI, 8'h80);
    wr(`PRX_ADDR_THR_LO, 8'h40);
    wr(`PRX_ADDR_EVMODE, {5'h00, `PRX_EV_DONE});
    settle(16'h0FFF, SETTLE);
    pin(1'b1);
    rd(`PRX_ADDR_RESULT, d);
    check(d, 8'h00);
    $display("test standby done");
    wr(`PRX_ADDR_PWR, 8'h01);
    for (int i = 0; i < 6; i++) begin
      r = i == 0 ? 16'h0FFF : i == 1 ? 16'h4000 : 16'h1000 + ($random(seed) & 16'h2FFF);
      settle(r, 0);
      for (int k = 0; k < 2000 && event_pin_n_o !== 1'b0; k++) @(posedge clock_i);
      pin(1'b0);
      repeat (4) @(posedge clock_i);
      rd(`PRX_ADDR_STATUS, d);
      check(d, 8'h00);
      repeat (4) @(posedge clock_i);
      rd(`PRX_ADDR_RESULT, d);
      check(d, model_code(r));
      repeat (4) @(posedge clock_i);
      pin(1'b1);
      rd(`PRX_ADDR_STATUS, d);
      check(d, 8'h40);
    end
    wr(`PRX_ADDR_CEIL, 8'h77);
    wr(`PRX_ADDR_THR_HI, 8'h11, 12);
    rd(`PRX_ADDR_CEIL, d);
    check(d, CE);
    rd(`PRX_ADDR_THR_HI, d);
    check(d, 8'h80);
    $display("test conversions done");
    run_mode(`PRX_EV_COMP);
    run_mode(`PRX_EV_WAKE);
    wr(`PRX_ADDR_EVMODE, 8'h00);
    repeat (4) @(posedge clock_i);
    pin(1'b1);
    print_verdict();
  end
endmodule : proximity_readout_event_pin_tb
`default_nettype wire
